// *** verilog/mac_addr_filter_pause_regs.v ***
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mac_filter_regs.vh"

module mac_addr_filter_pause_regs #(
  parameter integer PAIRS = 4
) (
  input  wire        clk,
  input  wire        srst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        irq,
  input  wire        bit_tick,
  input  wire        pause_load,
  input  wire [15:0] pause_load_value,
  output wire        pause_active,
  input  wire        rx_addr_valid,
  input  wire [47:0] rx_dest_addr,
  input  wire        rx_type_valid,
  input  wire [15:0] rx_type_field,
  output reg         filter_valid,
  output reg         addr_match,
  output reg  [3:0]  addr_match_vec,
  output reg         hash_match,
  output reg         type_valid,
  output reg         type_match,
  output reg         rmii_mode,
  input  wire        tx_clk_in,
  output wire        tx_clk_gated
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // True when the word index selects a given register
  function hit;
    input [4:0] a;
    input [4:0] idx;
    begin
      hit = (a == idx);
    end
  endfunction

  // Word index of pair n, lower word when hi is 0, upper when 1
  function [4:0] pair_word;
    input integer n;
    input integer hi;
    integer w;
    begin
      w         = `IDX_MATCH_BASE + `MATCH_STRIDE * n + hi;
      pair_word = w[4:0];
    end
  endfunction

  // Hash index: bit i is the xor of every sixth address bit from i
  function [`HASH_IDX_W-1:0] hash_idx;
    input [47:0] da;
    integer i;
    integer k;
    begin
      hash_idx = {`HASH_IDX_W{1'b0}};
      for (i = 0; i < `HASH_IDX_W; i = i + 1) begin
        for (k = i; k < 48; k = k + `HASH_IDX_W) begin
          hash_idx[i] = hash_idx[i] ^ da[k];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  reg         ack_q;
  wire        req   = avs_read | avs_write;
  wire        wr_ok = avs_write & ack_q;
  wire        rd_ok = avs_read & ack_q;

  // One wait cycle per access, answer on the second cycle
  assign avs_waitrequest = req & ~ack_q;

  always @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [`PAUSE_W-1:0]    pause_q;
  reg [`PAUSE_CNT_W-1:0] bit_cnt_q;
  reg [31:0]            hash_lo_q;
  reg [31:0]            hash_hi_q;
  reg [31:0]            match_lo_q [0:PAIRS-1];
  reg [`TOP_W-1:0]      match_hi_q [0:PAIRS-1];
  reg [`TYPE_W-1:0]     type_q;
  reg                   clk_gate_q;
  reg [`INT_W-1:0]      int_stat_q;
  reg [`INT_W-1:0]      int_en_q;

  // Interface register reset image, split into its bits below
  localparam [1:0] RST_IFACE_V = `RST_IFACE;

  // Hash filter words
  always @(posedge clk) begin
    if (srst) begin
      hash_lo_q <= `RST_WORD;
      hash_hi_q <= `RST_WORD;
    end else begin
      if (wr_ok && hit(avs_address, `IDX_HASH_LO))
        hash_lo_q <= avs_writedata;
      if (wr_ok && hit(avs_address, `IDX_HASH_HI))
        hash_hi_q <= avs_writedata;
    end
  end

  // Exact-match pairs, lower then upper word of each
  genvar g;
  generate
    for (g = 0; g < PAIRS; g = g + 1) begin : g_pair
      always @(posedge clk) begin
        if (srst) begin
          match_lo_q[g] <= `RST_WORD;
          match_hi_q[g] <= {`TOP_W{1'b0}};
        end else begin
          if (wr_ok && hit(avs_address, pair_word(g, 0)))
            match_lo_q[g] <= avs_writedata;
          if (wr_ok && hit(avs_address, pair_word(g, 1)))
            match_hi_q[g] <= avs_writedata[`TOP_W-1:0];
        end
      end
    end
  endgenerate

  // Write decodes of the type and interface words
  wire wr_type  = wr_ok && hit(avs_address, `IDX_TYPE);
  wire wr_iface = wr_ok && hit(avs_address, `IDX_IFACE);

  // Type compare value and interface control bits
  always @(posedge clk) begin
    if (srst) begin
      type_q     <= {`TYPE_W{1'b0}};
      rmii_mode  <= RST_IFACE_V[`RMII_BIT];
      clk_gate_q <= RST_IFACE_V[`CLKGATE_BIT];
    end else begin
      if (wr_type)
        type_q <= avs_writedata[`TYPE_W-1:0];
      if (wr_iface) begin
        rmii_mode  <= avs_writedata[`RMII_BIT];
        clk_gate_q <= avs_writedata[`CLKGATE_BIT];
      end
    end
  end

  // Transceiver clock gate; plain AND, so software should change it while idle
  // Gate bit clear holds the output low to save power
  assign tx_clk_gated = tx_clk_in & clk_gate_q;

  // ----------------------------------------
  // Pause countdown
  // ----------------------------------------
  wire bits_done   = (bit_cnt_q == `PAUSE_BITS - 1);
  wire sw_pause_wr = wr_ok && hit(avs_address, `IDX_PAUSE);
  // A tick counts only when no write or load replaces the count this cycle
  wire count_step  = pause_active & bit_tick & ~sw_pause_wr & ~pause_load;
  wire pz_event    = count_step & bits_done & (pause_q == `PAUSE_STEP);

  assign pause_active = (pause_q != {`PAUSE_W{1'b0}});

  // Software write wins, then a received pause value, then the countdown
  always @(posedge clk) begin
    if (srst) begin
      pause_q   <= {`PAUSE_W{1'b0}};
      bit_cnt_q <= {`PAUSE_CNT_W{1'b0}};
    end else if (sw_pause_wr) begin
      pause_q   <= avs_writedata[`PAUSE_W-1:0];
      bit_cnt_q <= {`PAUSE_CNT_W{1'b0}};
    end else if (pause_load) begin
      pause_q   <= pause_load_value;
      bit_cnt_q <= {`PAUSE_CNT_W{1'b0}};
    end else if (count_step) begin
      bit_cnt_q <= bit_cnt_q + `BIT_STEP;
      if (bits_done)
        pause_q <= pause_q - `PAUSE_STEP;
    end
  end

  // ----------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------
  wire stat_rd  = rd_ok && hit(avs_address, `IDX_INT_STAT);
  wire stat_wc  = wr_ok && hit(avs_address, `IDX_INT_CLR);
  // Clear only what the read returned; an event after the capture survives
  wire stat_rdc = stat_rd && avs_readdata[`PZ_BIT];

  // Sticky flag; a new event in the clearing cycle keeps it set
  always @(posedge clk) begin
    if (srst) begin
      int_stat_q <= {`INT_W{1'b0}};
      int_en_q   <= {`INT_W{1'b0}};
    end else begin
      if (pz_event)
        int_stat_q[`PZ_BIT] <= 1'b1;
      else if (stat_rdc || (stat_wc && avs_writedata[`PZ_BIT]))
        int_stat_q[`PZ_BIT] <= 1'b0;
      if (wr_ok && hit(avs_address, `IDX_INT_EN))
        int_en_q <= avs_writedata[`INT_W-1:0];
    end
  end

  assign irq = |(int_stat_q & int_en_q);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [31:0] rd_d;
  integer    p;

  // Unmapped and write-only words read as zero
  always @* begin
    rd_d = `RST_WORD;
    case (avs_address)
      `IDX_PAUSE:    rd_d[`PAUSE_W-1:0] = pause_q;
      `IDX_HASH_LO:  rd_d = hash_lo_q;
      `IDX_HASH_HI:  rd_d = hash_hi_q;
      `IDX_TYPE:     rd_d[`TYPE_W-1:0] = type_q;
      `IDX_IFACE: begin
        rd_d[`RMII_BIT]    = rmii_mode;
        rd_d[`CLKGATE_BIT] = clk_gate_q;
      end
      `IDX_INT_STAT: rd_d[`INT_W-1:0] = int_stat_q;
      `IDX_INT_EN:   rd_d[`INT_W-1:0] = int_en_q;
      default: begin
        for (p = 0; p < PAIRS; p = p + 1) begin
          if (hit(avs_address, pair_word(p, 0)))
            rd_d = match_lo_q[p];
          if (hit(avs_address, pair_word(p, 1)))
            rd_d[`TOP_W-1:0] = match_hi_q[p];
        end
      end
    endcase
  end

  // First cycle of a read, the only one in which read data is loaded
  wire rd_capture = avs_read & ~ack_q;

  // Captured in the wait cycle, stands while waitrequest is low
  always @(posedge clk) begin
    if (srst)
      avs_readdata <= `RST_WORD;
    else if (rd_capture)
      avs_readdata <= rd_d;
  end

  // ----------------------------------------
  // Receive-side comparisons
  // ----------------------------------------
  reg [3:0] pair_hit;
  reg [63:0] hash_vec;
  integer   q;

  // Hash bit picked by the received destination, and the type compare
  wire [`HASH_IDX_W-1:0] rx_hash_idx = hash_idx(rx_dest_addr);
  wire                   rx_hash_hit = hash_vec[rx_hash_idx];
  wire                   rx_type_hit = (rx_type_field == type_q);

  // Destination byte 0 in bits 7:0, its bit 0 first on the wire
  always @* begin
    pair_hit = 4'h0;
    hash_vec = {hash_hi_q, hash_lo_q};
    for (q = 0; q < PAIRS; q = q + 1)
      pair_hit[q] = ({match_hi_q[q], match_lo_q[q]} == rx_dest_addr);
  end

  // Registered match results, one cycle after each strobe
  always @(posedge clk) begin
    if (srst) begin
      filter_valid   <= 1'b0;
      addr_match     <= 1'b0;
      addr_match_vec <= 4'h0;
      hash_match     <= 1'b0;
      type_valid     <= 1'b0;
      type_match     <= 1'b0;
    end else begin
      filter_valid <= rx_addr_valid;
      type_valid   <= rx_type_valid;
      if (rx_addr_valid) begin
        addr_match_vec <= pair_hit;
        addr_match     <= |pair_hit;
        hash_match     <= rx_hash_hit;
      end
      if (rx_type_valid)
        type_match <= rx_type_hit;
    end
  end

endmodule // mac_addr_filter_pause_regs

`default_nettype wire

// *** verilog/mac_filter_regs.vh ***
// Overview of operation
// - A 16-bit pause count, read and written by software, counts down once per 512 bit times while non-zero.
// - The lower hash register holds bits 31 to 0 of the 64-bit hash filter and reads back.
// - The upper hash register holds bits 63 to 32 of the 64-bit hash filter and reads back.
// - Each match pair's lower register holds the low 32 destination address bits to compare.
// - Bit 0 of each lower register is the first received bit of the first byte, the group bit.
// - Each match pair's upper register holds the top 16 address bits in 15 to 0; 31 to 16 unused.
// - Four independent match pairs of lower and upper registers, all read and write.
// - A 16-bit type value in bits 15 to 0 is compared with each received type/length field.
// - The pause count counting down from 1 to zero sets a pause-zero flag that a status read clears; a write or load of zero does not.
// - Bit 0 of the interface register selects RMII when set and MII when clear.
// - Bit 1 of the interface register passes the transceiver clock when set, gates it when clear.
`ifndef MAC_FILTER_REGS_VH
`define MAC_FILTER_REGS_VH

// ----------------------------------------
// Register word indices
// ----------------------------------------
`define IDX_PAUSE      5'h00
`define IDX_HASH_LO    5'h01
`define IDX_HASH_HI    5'h02
`define IDX_MATCH_BASE 5'h03
`define IDX_TYPE       5'h0b
`define IDX_IFACE      5'h0c
`define IDX_INT_STAT   5'h0d
`define IDX_INT_CLR    5'h0e
`define IDX_INT_EN     5'h0f

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PAUSE_W        16
`define TOP_W          16
`define TYPE_W         16
`define RMII_BIT       0
`define CLKGATE_BIT    1
`define PZ_BIT         0
`define INT_W          1
`define PAUSE_BITS     512
`define PAUSE_CNT_W    9
`define HASH_IDX_W     6
`define MATCH_STRIDE   2
`define PAUSE_STEP     16'h0001
`define BIT_STEP       9'h001
`define RST_WORD       32'h0000_0000
`define RST_IFACE      2'h0

`endif

// *** sim/mac_filter_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_filter_props (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       bit_tick,
  input wire logic       pause_load,
  input wire logic       irq,
  input wire logic       pause_active,
  input wire logic       rx_addr_valid,
  input wire logic       rx_type_valid,
  input wire logic       filter_valid,
  input wire logic       type_valid,
  input wire logic       addr_match,
  input wire logic [3:0] addr_match_vec,
  input wire logic       rmii_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Bus request and its single wait state
  sequence s_req; $rose(avs_read | avs_write); endsequence
  sequence s_ack; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_ws; s_req |-> s_ack; endproperty
  a_ws: assert property (p_ws) else $error("wait state wrong");
  property p_fv; filter_valid == $past(rx_addr_valid); endproperty
  a_fv: assert property (p_fv) else $error("filter valid wrong");
  property p_tv; type_valid == $past(rx_type_valid); endproperty
  a_tv: assert property (p_tv) else $error("type valid wrong");
  property p_or; filter_valid |-> addr_match == (|addr_match_vec); endproperty
  a_or: assert property (p_or) else $error("match summary wrong");
  property p_hd; !filter_valid |-> $stable(addr_match_vec); endproperty
  a_hd: assert property (p_hd) else $error("match not held");
  property p_pz; $fell(pause_active) |-> $past(bit_tick | avs_write | pause_load); endproperty
  a_pz: assert property (p_pz) else $error("pause ended early");
  property p_id; !pause_active && !avs_write && !pause_load |=> !pause_active; endproperty
  a_id: assert property (p_id) else $error("idle pause moved");
  property p_rm; $changed(rmii_mode) |-> $past(avs_write & ~avs_waitrequest); endproperty
  a_rm: assert property (p_rm) else $error("mode changed alone");
  property p_iq; $rose(irq) |-> $past(avs_write) || $fell(pause_active); endproperty
  a_iq: assert property (p_iq) else $error("interrupt without cause");
endmodule // mac_filter_props
bind mac_addr_filter_pause_regs mac_filter_props i_mac_filter_props (.clk, .srst, .avs_read,
  .avs_write, .avs_waitrequest, .bit_tick, .pause_load, .irq, .pause_active, .rx_addr_valid,
  .rx_type_valid,
  .filter_valid, .type_valid, .addr_match, .addr_match_vec, .rmii_mode);
`default_nettype wire

// *** sim/phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  input  wire logic        clk,
  input  wire logic        tick_en,
  output var  logic        bit_tick,
  output var  logic        tx_clk_in,
  output var  logic        rx_valid,
  output var  logic [47:0] rx_dest_addr,
  output var  logic [15:0] rx_type_field
);
  logic ph;
  // Idle lines at time zero
  initial {ph, bit_tick, tx_clk_in, rx_valid, rx_dest_addr, rx_type_field} = '0;
  // Free running transceiver clock
  always #20 tx_clk_in = ~tx_clk_in;
  // Slow line: one bit pulse every other cycle
  always @(posedge clk) begin
    ph <= ~ph;
    bit_tick <= tick_en & ph;
  end
  // One header, byte0 bit0 first; released lines show the inverse
  task send(input logic [47:0] da, input logic [15:0] ty);
    @(posedge clk);
    {rx_valid, rx_dest_addr, rx_type_field} <= {1'b1, da, ty};
    @(posedge clk);
    {rx_valid, rx_dest_addr, rx_type_field} <= {1'b0, ~da, ~ty};
  endtask
endmodule // phy_model
`default_nettype wire

// *** sim/mac_addr_filter_pause_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_addr_filter_pause_regs_tb_top;
  logic        clk, srst, avs_read, avs_write, tick_en, pause_load;
  logic [15:0] pause_load_value;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, q;
  wire  [31:0] avs_readdata;
  wire  [47:0] rx_dest_addr;
  wire  [15:0] rx_type_field;
  wire  [3:0]  addr_match_vec;
  wire         avs_waitrequest, irq, bit_tick, pause_active, rx_valid, filter_valid, addr_match;
  wire         hash_match, type_valid, type_match, rmii_mode, tx_clk_in, tx_clk_gated;
  int          fail_count, compares;
  mac_addr_filter_pause_regs i_mac_addr_filter_pause_regs (.clk, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .bit_tick,
    .pause_load, .pause_load_value, .pause_active, .rx_addr_valid(rx_valid),
    .rx_dest_addr, .rx_type_valid(rx_valid), .rx_type_field, .filter_valid, .addr_match,
    .addr_match_vec, .hash_match, .type_valid, .type_match, .rmii_mode, .tx_clk_in,
    .tx_clk_gated);
  phy_model i_phy_model (.clk, .tick_en, .bit_tick, .tx_clk_in, .rx_valid, .rx_dest_addr,
    .rx_type_field);
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task chk(input string nm, input logic [47:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One bus access, held until waitrequest is low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    {avs_read, avs_write, avs_address, avs_writedata} <= {~w, w, a, d};
    repeat (20) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    chk("waitrequest", avs_waitrequest, 1'b0);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
  endtask
  task rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", q, e);
  endtask
  // Every register from pause to interface written, then read back through its width
  task t_regs;
    logic [31:0] m;
    for (int i = 0; i < 13; i++) bus(1'b1, 5'(i), 32'ha5c3_9617 ^ i);
    for (int i = 0; i < 13; i++) begin
      m = (i == 12) ? 32'h3 : 32'hffff_ffff;
      if (i == 0 || i == 11 || (i > 3 && i < 11 && !i[0])) m = 32'hffff;
      rchk(5'(i), (32'ha5c3_9617 ^ i) & m);
    end
    bus(1'b1, 5'h1f, 32'hffff_ffff);
    rchk(5'h1f, 32'h0);
    bus(1'b1, 5'h00, 32'h0);
  endtask
  // Pairs, type and hash bits against received headers
  task t_filter;
    logic [47:0] da;
    for (int n = 0; n < 4; n++) begin
      da = 48'h3c5a_7e81_0000 + n;
      bus(1'b1, 5'(3 + 2 * n), da[31:0]);
      bus(1'b1, 5'(4 + 2 * n), {16'h0, da[47:32]});
    end
    bus(1'b1, 5'h0b, 32'h88b5);
    bus(1'b1, 5'h01, 32'h1);
    bus(1'b1, 5'h02, 32'h2000_0000);
    for (int n = 0; n < 6; n++) begin
      da = (n < 4) ? 48'h3c5a_7e81_0000 + n : (n == 4) ? 48'h3d5a_7e81_0000 : 48'h820;
      i_phy_model.send(da, 16'h88b4 + 16'(n == 2));
      #1;
      chk("valids", {filter_valid, type_valid}, 2'b11);
      chk("match", {addr_match, addr_match_vec}, (n < 4) ? 5'h10 | (5'h1 << n) : 5'h0);
      chk("hash_match", hash_match, n > 3);
      chk("type_match", type_match, n == 2);
    end
  endtask
  // Written count runs to zero; one tick per two cycles, 512 ticks per step
  task count_down(input logic [15:0] v, input int lo);
    int n;
    n = 0;
    bus(1'b1, 5'h00, {16'h0, v});
    tick_en <= 1'b1;
    #1;
    while (pause_active !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    tick_en <= 1'b0;
    chk("pause_span", n >= lo && n <= lo + 1, 1'b1);
  endtask
  // Load pulse, countdowns, flag masked, enabled, cleared by read and by write
  task t_pause;
    @(posedge clk);
    {pause_load, pause_load_value} <= {1'b1, 16'h0003};
    @(posedge clk);
    pause_load <= 1'b0;
    rchk(5'h00, 32'h3);
    count_down(16'h2, 2048);
    @(posedge clk);
    #1;
    chk("irq", irq, 1'b0);
    bus(1'b1, 5'h0f, 32'h1);
    #1;
    chk("irq", irq, 1'b1);
    rchk(5'h0d, 32'h1);
    rchk(5'h0d, 32'h0);
    #1;
    chk("irq", irq, 1'b0);
    count_down(16'h1, 1024);
    chk("irq", irq, 1'b1);
    bus(1'b1, 5'h0e, 32'h1);
    #1;
    chk("irq", irq, 1'b0);
    rchk(5'h0d, 32'h0);
  endtask
  // Interface mode and transceiver clock gate
  task t_iface;
    for (int v = 0; v < 4; v++) begin
      bus(1'b1, 5'h0c, v);
      #1;
      chk("rmii_mode", rmii_mode, v[0]);
      repeat (2) begin
        #20;
        chk("tx_clk_gated", tx_clk_gated, tx_clk_in & v[1]);
      end
    end
  endtask
  task complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Reset, scenarios, verdict
  initial begin
    {srst, avs_read, avs_write, tick_en, avs_address, avs_writedata} = {4'b1000, 37'h0};
    {pause_load, pause_load_value} = 17'h0;
    fail_count = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_filter;
    t_pause;
    t_iface;
    complete_run;
  end
  // Watchdog
  initial begin
    #500000;
    chk("watchdog", 1'b1, 1'b0);
    complete_run;
  end
endmodule // mac_addr_filter_pause_regs_tb_top
`default_nettype wire
